// ===== src/timer16_pkg.sv
// constants shared by the 16-bit capture/compare timer files
// assumes: register byte address = 4 * register index, data in low byte
package timer16_pkg;
   // ---------------------------------------------------------------
   // register indices
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL_B = 8'h51;
   localparam logic [7:0] IDX_CTRL_A = 8'h52;
   localparam logic [7:0] IDX_STATUS = 8'h53;
   localparam logic [7:0] IDX_CAPA_HI = 8'h54;
   localparam logic [7:0] IDX_CAPA_LO = 8'h55;
   localparam logic [7:0] IDX_CMPA_HI = 8'h56;
   localparam logic [7:0] IDX_CMPA_LO = 8'h57;
   localparam logic [7:0] IDX_CNT_HI = 8'h58;
   localparam logic [7:0] IDX_CNT_LO = 8'h59;
   localparam logic [7:0] IDX_ALT_HI = 8'h5A;
   localparam logic [7:0] IDX_ALT_LO = 8'h5B;
   localparam logic [7:0] IDX_CAPB_HI = 8'h5C;
   localparam logic [7:0] IDX_CAPB_LO = 8'h5D;
   localparam logic [7:0] IDX_CMPB_HI = 8'h5E;
   localparam logic [7:0] IDX_CMPB_LO = 8'h5F;
   // ---------------------------------------------------------------
   // timer_control_a bits
   // ---------------------------------------------------------------
   localparam int CA_CAP_IE = 7;
   localparam int CA_CMP_IE = 6;
   localparam int CA_OVF_IE = 5;
   localparam int CA_FORCE_B = 4;
   localparam int CA_FORCE_A = 3;
   localparam int CA_LVL_B = 2;
   localparam int CA_EDGE_A = 1;
   localparam int CA_LVL_A = 0;
   // ---------------------------------------------------------------
   // timer_control_b bits
   // ---------------------------------------------------------------
   localparam int CB_PIN_A_EN = 7;
   localparam int CB_PIN_B_EN = 6;
   localparam int CB_OPM = 5;
   localparam int CB_PWM = 4;
   localparam int CB_CLK_HI = 3;
   localparam int CB_CLK_LO = 2;
   localparam int CB_EDGE_B = 1;
   localparam int CB_EXT_EDGE = 0;
   // ---------------------------------------------------------------
   // flag vector, same order as status bits 7..3
   // ---------------------------------------------------------------
   localparam int F_CAPA = 4;
   localparam int F_CMPA = 3;
   localparam int F_OVF = 2;
   localparam int F_CAPB = 1;
   localparam int F_CMPB = 0;
   // ---------------------------------------------------------------
   // values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'hFFFC;
   localparam logic [15:0] OPM_CAPTURE = 16'hFFFD;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [1:0] CLK_DIV4 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV8 = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;
   localparam logic [2:0] MASK_DIV2 = 3'h1;
   localparam logic [2:0] MASK_DIV4 = 3'h3;
   localparam logic [2:0] MASK_DIV8 = 3'h7;
endpackage

// ===== src/capture_edge_det.sv
// selectable edge detector for one capture input
// assumes: input already synchronous to clk
`timescale 1ns/1ps
module capture_edge_det (
   input wire logic clk,
   input wire logic reset,
   input wire logic level,
   input wire logic risingSel,
   output logic edgeSeen
);
   typedef struct packed {
      logic prev;
      logic primed;
   } state_t;
   state_t s_r, s_nxt;

   // no edge before one real sample, so reset cannot fake a transition
   always_comb begin
      s_nxt.prev = level;
      s_nxt.primed = 1'b1;
      edgeSeen = s_r.primed && (level != s_r.prev) && (level == risingSel);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// ===== src/timer_prescaler.sv
// counter clock source: cpu clock divided, or external clock edges
// assumes: external clock sampled as a synchronous input
`timescale 1ns/1ps
module timer_prescaler #(
   parameter bit HAS_EXT = 1'b1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic [1:0] clkSel,
   input wire logic extClk,
   input wire logic extRising,
   output logic tick
);
   typedef struct packed {
      logic [2:0] div;
      logic extPrev;
      logic primed;
   } state_t;
   state_t s_r, s_nxt;
   logic [2:0] mask;

   always_comb begin
      s_nxt = s_r;
      s_nxt.extPrev = extClk;
      s_nxt.primed = 1'b1;
      unique case (clkSel)
         timer16_pkg::CLK_DIV2: mask = timer16_pkg::MASK_DIV2;
         timer16_pkg::CLK_DIV8: mask = timer16_pkg::MASK_DIV8;
         default: mask = timer16_pkg::MASK_DIV4;
      endcase
      tick = 1'b0;
      // divider frozen while stopped: restart keeps the phase
      if (run) begin
         if (clkSel == timer16_pkg::CLK_EXT) begin
            tick = HAS_EXT && s_r.primed && (extClk != s_r.extPrev)
                   && (extClk == extRising);
         end else begin
            s_nxt.div = s_r.div + 3'h1;
            tick = ((s_r.div & mask) == mask);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// ===== src/timer16_capture_compare_ctrl.sv
// 16-bit capture/compare timer: control, flags, interrupt, low power
// assumes: APB master, synchronous pins, cpuHalt high during halt
// Notes on behaviour
// - wait state: timer keeps running, interrupt wakes
// - halt freezes counter; it resumes from the held count
// - edge during halt arms; capture at exit
// - five events raise flags, wake wait
// - one shared request, gated by enables, mask
// - capture enable gates both capture flags
// - compare enable gates both compare flags
// - overflow enable gates overflow flag
// - force B copies level B to pin B
// - force A copies level A to pin A
// - level B on B match; pin A in modes
// - capture A edge select: 0 fall, 1 rise
// - level A drives pin A on A match
// - pin A enable connects the pin, gates its updates
// - pin B enable connects the pin, gates its updates
// - one-pulse: capture A edge starts pulse
// - pwm: width from compare A, period B
// - clock select: div4, div2, div8, external
// - no external pin: external setting stops counter
// - two control registers, a status register, six data pairs
// - both control registers reset to zero
// - flag clear: status read, then low access
// - pwm never sets compare flags
// - force bits ignored in one-pulse, pwm
`timescale 1ns/1ps
module timer16_capture_compare_ctrl #(
   parameter bit HAS_EXT_CLK = 1'b1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic captureInputA,
   input wire logic captureInputB,
   input wire logic extClkIn,
   input wire logic cpuHalt,
   input wire logic irqMaskSet,
   output logic comparePinA,
   output logic comparePinAEnable,
   output logic comparePinB,
   output logic comparePinBEnable,
   output logic timerIrq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctrlA;
      logic [7:0] ctrlB;
      logic timd;
      logic [4:0] flags;
      logic [4:0] clrArm;
      logic [15:0] cnt;
      logic [15:0] capA;
      logic [15:0] capB;
      logic [15:0] cmpA;
      logic [15:0] cmpB;
      logic [15:0] cmpAAct;
      logic [15:0] cmpBAct;
      logic [1:0] inhibit;
      logic [1:0] armed;
      logic haltPrev;
      logic pinA;
      logic pinB;
      logic pinAEn;
      logic pinBEn;
      logic irq;
      logic rdy;
      logic err;
      logic [7:0] rdata;
   } state_t;
   state_t s_r, s_nxt;

   logic edgeA, edgeB, tick, run, pwm, one_pulse_mode_bit;
   logic mapped, access, done, wrDone, anyDone;
   logic matchA, matchB, ovf, capAEv, capBEv, haltExit;
   logic [7:0] idx, wbyte, rd8;
   logic [4:0] setF, clrF, enMask;
   logic [15:0] cntInc;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   capture_edge_det edgeDetA (
      .clk(clk),
      .reset(reset),
      .level(captureInputA),
      .risingSel(s_r.ctrlA[timer16_pkg::CA_EDGE_A]),
      .edgeSeen(edgeA)
   );

   capture_edge_det edgeDetB (
      .clk(clk),
      .reset(reset),
      .level(captureInputB),
      .risingSel(s_r.ctrlB[timer16_pkg::CB_EDGE_B]),
      .edgeSeen(edgeB)
   );

   timer_prescaler #(
      .HAS_EXT(HAS_EXT_CLK)
   ) prescaler (
      .clk(clk),
      .reset(reset),
      .run(run),
      .clkSel(s_r.ctrlB[timer16_pkg::CB_CLK_HI:timer16_pkg::CB_CLK_LO]),
      .extClk(extClkIn),
      .extRising(s_r.ctrlB[timer16_pkg::CB_EXT_EDGE]),
      .tick(tick)
   );

   // ---------------------------------------------------------------
   // decode and read mux
   // ---------------------------------------------------------------
   always_comb begin
      idx = paddr[9:2];
      wbyte = pwdata[7:0];
      mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
               && (idx >= timer16_pkg::IDX_CTRL_B)
               && (idx <= timer16_pkg::IDX_CMPB_LO);
      access = psel && penable && !s_r.rdy;
      done = psel && penable && s_r.rdy;
      anyDone = done && mapped;
      wrDone = anyDone && pwrite;
      unique case (idx)
         timer16_pkg::IDX_CTRL_B: rd8 = s_r.ctrlB;
         timer16_pkg::IDX_CTRL_A: rd8 = s_r.ctrlA;
         timer16_pkg::IDX_STATUS: rd8 = {s_r.flags, s_r.timd, 2'h0};
         timer16_pkg::IDX_CAPA_HI: rd8 = s_r.capA[15:8];
         timer16_pkg::IDX_CAPA_LO: rd8 = s_r.capA[7:0];
         timer16_pkg::IDX_CMPA_HI: rd8 = s_r.cmpA[15:8];
         timer16_pkg::IDX_CMPA_LO: rd8 = s_r.cmpA[7:0];
         timer16_pkg::IDX_CNT_HI: rd8 = s_r.cnt[15:8];
         timer16_pkg::IDX_CNT_LO: rd8 = s_r.cnt[7:0];
         timer16_pkg::IDX_ALT_HI: rd8 = s_r.cnt[15:8];
         timer16_pkg::IDX_ALT_LO: rd8 = s_r.cnt[7:0];
         timer16_pkg::IDX_CAPB_HI: rd8 = s_r.capB[15:8];
         timer16_pkg::IDX_CAPB_LO: rd8 = s_r.capB[7:0];
         timer16_pkg::IDX_CMPB_HI: rd8 = s_r.cmpB[15:8];
         timer16_pkg::IDX_CMPB_LO: rd8 = s_r.cmpB[7:0];
         default: rd8 = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // events
   // ---------------------------------------------------------------
   always_comb begin
      pwm = s_r.ctrlB[timer16_pkg::CB_PWM];
      // pwm wins when both mode bits are set
      one_pulse_mode_bit = s_r.ctrlB[timer16_pkg::CB_OPM] && !pwm;
      // wait state is not seen here at all: counting goes on
      run = !cpuHalt && !s_r.timd;
      cntInc = s_r.cnt + 16'h0001;
      matchA = tick && !s_r.inhibit[0] && (cntInc == s_r.cmpAAct);
      matchB = tick && !s_r.inhibit[1] && (cntInc == s_r.cmpBAct);
      ovf = tick && (s_r.cnt == timer16_pkg::CNT_MAX);
      // capture pin A is cut off from the timer in pwm
      capAEv = edgeA && !pwm && !cpuHalt;
      capBEv = edgeB && !cpuHalt;
      haltExit = s_r.haltPrev && !cpuHalt;
      enMask = {s_r.ctrlA[timer16_pkg::CA_CAP_IE],
                s_r.ctrlA[timer16_pkg::CA_CMP_IE],
                s_r.ctrlA[timer16_pkg::CA_OVF_IE],
                s_r.ctrlA[timer16_pkg::CA_CAP_IE],
                s_r.ctrlA[timer16_pkg::CA_CMP_IE]};
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      setF = 5'h00;
      clrF = 5'h00;
      s_nxt.haltPrev = cpuHalt;

      // bus: one wait cycle so read data comes from a flip-flop
      s_nxt.rdy = access;
      s_nxt.err = access && !mapped;
      if (access) begin
         s_nxt.rdata = (mapped && !pwrite) ? rd8 : 8'h00;
      end

      // counter
      if (tick) begin
         s_nxt.cnt = cntInc;
      end
      if (ovf) begin
         setF[timer16_pkg::F_OVF] = 1'b1;
      end

      // compare actives follow the registers, in pwm only per period
      if (!pwm) begin
         s_nxt.cmpAAct = s_r.cmpA;
         s_nxt.cmpBAct = s_r.cmpB;
      end

      if (pwm) begin
         if (matchA && s_r.ctrlB[timer16_pkg::CB_PIN_A_EN]) begin
            s_nxt.pinA = s_r.ctrlA[timer16_pkg::CA_LVL_A];
         end
         if (matchB) begin
            s_nxt.cnt = timer16_pkg::CNT_RESET;
            s_nxt.cmpAAct = s_r.cmpA;
            s_nxt.cmpBAct = s_r.cmpB;
            setF[timer16_pkg::F_CAPA] = 1'b1;
            if (s_r.ctrlB[timer16_pkg::CB_PIN_A_EN]) begin
               s_nxt.pinA = s_r.ctrlA[timer16_pkg::CA_LVL_B];
            end
         end
         // no compare flag is ever raised here
      end else if (one_pulse_mode_bit) begin
         if (capAEv) begin
            s_nxt.cnt = timer16_pkg::CNT_RESET;
            s_nxt.capA = timer16_pkg::OPM_CAPTURE;
            setF[timer16_pkg::F_CAPA] = 1'b1;
            if (s_r.ctrlB[timer16_pkg::CB_PIN_A_EN]) begin
               s_nxt.pinA = s_r.ctrlA[timer16_pkg::CA_LVL_B];
            end
         end
         if (matchA && s_r.ctrlB[timer16_pkg::CB_PIN_A_EN]) begin
            s_nxt.pinA = s_r.ctrlA[timer16_pkg::CA_LVL_A];
         end
         // level B belongs to the pulse, so compare B only flags
         if (matchB) begin
            setF[timer16_pkg::F_CMPB] = 1'b1;
         end
      end else begin
         if (capAEv) begin
            s_nxt.capA = s_r.cnt;
            setF[timer16_pkg::F_CAPA] = 1'b1;
         end
         // flags keep working with the pins disconnected
         if (matchA) begin
            setF[timer16_pkg::F_CMPA] = 1'b1;
            if (s_r.ctrlB[timer16_pkg::CB_PIN_A_EN]) begin
               s_nxt.pinA = s_r.ctrlA[timer16_pkg::CA_LVL_A];
            end
         end
         if (matchB) begin
            setF[timer16_pkg::F_CMPB] = 1'b1;
            if (s_r.ctrlB[timer16_pkg::CB_PIN_B_EN]) begin
               s_nxt.pinB = s_r.ctrlA[timer16_pkg::CA_LVL_B];
            end
         end
      end
      if (capBEv) begin
         s_nxt.capB = s_r.cnt;
         setF[timer16_pkg::F_CAPB] = 1'b1;
      end

      // halt: selected edges only arm, capture happens at exit
      if (cpuHalt) begin
         s_nxt.armed[0] = s_r.armed[0] || (edgeA && !pwm);
         s_nxt.armed[1] = s_r.armed[1] || edgeB;
      end
      if (haltExit) begin
         s_nxt.armed = 2'h0;
         if (s_r.armed[0]) begin
            s_nxt.capA = s_r.cnt;
            setF[timer16_pkg::F_CAPA] = 1'b1;
         end
         if (s_r.armed[1]) begin
            s_nxt.capB = s_r.cnt;
            setF[timer16_pkg::F_CAPB] = 1'b1;
         end
      end

      // two-step flag clear: status read arms, low access clears
      if (anyDone && !pwrite && idx == timer16_pkg::IDX_STATUS) begin
         s_nxt.clrArm = s_r.flags;
      end
      if (anyDone) begin
         unique case (idx)
            timer16_pkg::IDX_CAPA_LO: clrF[timer16_pkg::F_CAPA] = 1'b1;
            timer16_pkg::IDX_CMPA_LO: clrF[timer16_pkg::F_CMPA] = 1'b1;
            // the alternate view leaves overflow alone
            timer16_pkg::IDX_CNT_LO: clrF[timer16_pkg::F_OVF] = 1'b1;
            timer16_pkg::IDX_CAPB_LO: clrF[timer16_pkg::F_CAPB] = 1'b1;
            timer16_pkg::IDX_CMPB_LO: clrF[timer16_pkg::F_CMPB] = 1'b1;
            default: clrF = 5'h00;
         endcase
         clrF = clrF & s_r.clrArm;
         s_nxt.clrArm = s_nxt.clrArm & ~clrF;
      end

      // register writes
      if (wrDone) begin
         unique case (idx)
            timer16_pkg::IDX_CTRL_A: begin
               s_nxt.ctrlA = wbyte;
               if (!pwm && !one_pulse_mode_bit) begin
                  if (wbyte[timer16_pkg::CA_FORCE_A]
                      && s_r.ctrlB[timer16_pkg::CB_PIN_A_EN]) begin
                     s_nxt.pinA = wbyte[timer16_pkg::CA_LVL_A];
                  end
                  if (wbyte[timer16_pkg::CA_FORCE_B]
                      && s_r.ctrlB[timer16_pkg::CB_PIN_B_EN]) begin
                     s_nxt.pinB = wbyte[timer16_pkg::CA_LVL_B];
                  end
               end
            end
            timer16_pkg::IDX_CTRL_B: s_nxt.ctrlB = wbyte;
            timer16_pkg::IDX_STATUS: s_nxt.timd = wbyte[2];
            // high byte alone inhibits compare until the low byte
            timer16_pkg::IDX_CMPA_HI: begin
               s_nxt.cmpA[15:8] = wbyte;
               s_nxt.inhibit[0] = 1'b1;
            end
            timer16_pkg::IDX_CMPA_LO: begin
               s_nxt.cmpA[7:0] = wbyte;
               s_nxt.inhibit[0] = 1'b0;
            end
            timer16_pkg::IDX_CMPB_HI: begin
               s_nxt.cmpB[15:8] = wbyte;
               s_nxt.inhibit[1] = 1'b1;
            end
            timer16_pkg::IDX_CMPB_LO: begin
               s_nxt.cmpB[7:0] = wbyte;
               s_nxt.inhibit[1] = 1'b0;
            end
            timer16_pkg::IDX_CNT_LO: s_nxt.cnt = timer16_pkg::CNT_RESET;
            timer16_pkg::IDX_ALT_LO: s_nxt.cnt = timer16_pkg::CNT_RESET;
            default: s_nxt.timd = s_r.timd;
         endcase
      end

      // halt freezes counter, captures, pins and flag setting
      if (cpuHalt) begin
         s_nxt.cnt = s_r.cnt;
         s_nxt.capA = s_r.capA;
         s_nxt.capB = s_r.capB;
         s_nxt.pinA = s_r.pinA;
         s_nxt.pinB = s_r.pinB;
         setF = 5'h00;
      end

      // set beats a clear in the same cycle
      s_nxt.flags = (s_r.flags & ~clrF) | setF;
      s_nxt.pinAEn = s_nxt.ctrlB[timer16_pkg::CB_PIN_A_EN] && !s_nxt.timd;
      s_nxt.pinBEn = s_nxt.ctrlB[timer16_pkg::CB_PIN_B_EN] && !s_nxt.timd;
      // level request; also the wake-up from wait
      s_nxt.irq = (|(s_nxt.flags & enMask)) && !irqMaskSet;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
         s_r.ctrlA <= timer16_pkg::CTRL_RESET;
         s_r.ctrlB <= timer16_pkg::CTRL_RESET;
         s_r.cnt <= timer16_pkg::CNT_RESET;
         s_r.cmpA <= timer16_pkg::CMP_RESET;
         s_r.cmpB <= timer16_pkg::CMP_RESET;
         s_r.cmpAAct <= timer16_pkg::CMP_RESET;
         s_r.cmpBAct <= timer16_pkg::CMP_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = {24'h00_0000, s_r.rdata};
   assign pready = s_r.rdy;
   assign pslverr = s_r.err;
   assign comparePinA = s_r.pinA;
   assign comparePinAEnable = s_r.pinAEn;
   assign comparePinB = s_r.pinB;
   assign comparePinBEnable = s_r.pinBEn;
   assign timerIrq = s_r.irq;
endmodule

// ===== tb/timer16_chk.sv
// checker for the timer block: bus answer, interrupt and pin outputs
// assumes: bound to the block's top module, one clock domain
`timescale 1ns/1ps
module timer16_chk (
   input logic clk,
   input logic reset,
   input logic psel,
   input logic penable,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic cpuHalt,
   input logic irqMaskSet,
   input logic comparePinA,
   input logic comparePinAEnable,
   input logic comparePinBEnable,
   input logic timerIrq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence accessWait;
      psel && penable && !pready;
   endsequence
   // no transfer ends here, so nothing clears
   sequence irqUntouched;
      !pready && timerIrq && !irqMaskSet;
   endsequence
   chk_ready_one_wait: assert property (accessWait |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   chk_error_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error with data");
   chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   chk_irq_masked: assert property ($past(irqMaskSet) |-> !timerIrq)
      else $error("request while masked");
   chk_irq_level: assert property (irqUntouched |=> timerIrq)
      else $error("request dropped");
   chk_halt_pin: assert property ($past(cpuHalt) |-> $stable(comparePinA))
      else $error("pin moved in halt");
   chk_reset_clear: assert property ($fell(reset) |->
      !timerIrq && !comparePinAEnable && !comparePinBEnable)
      else $error("outputs set at reset");
endmodule

bind timer16_capture_compare_ctrl timer16_chk u_chk (.clk(clk), .reset(reset), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuHalt(cpuHalt),
   .irqMaskSet(irqMaskSet), .comparePinA(comparePinA), .comparePinAEnable(comparePinAEnable),
   .comparePinBEnable(comparePinBEnable), .timerIrq(timerIrq));

// ===== tb/pin_partner.sv
// far-side pin model: capture inputs and external counter clock
// assumes: levels launched just after a rising clock edge
`timescale 1ns/1ps
module pin_partner (
   input wire logic clk,
   output logic captureInputA,
   output logic captureInputB,
   output logic extClkIn
);
   initial {captureInputA, captureInputB, extClkIn} = 3'b010;
   // held a few clocks so the synchronous sampler cannot miss a level
   task automatic setPin(input bit useB, input logic v);
      @(posedge clk);
      if (useB) captureInputB <= v;
      else captureInputA <= v;
      repeat (3) @(posedge clk);
   endtask
   // external clock stands still outside a burst
   task automatic extBurst(input int n);
      repeat (2 * n) begin
         @(posedge clk);
         extClkIn <= ~extClkIn;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule

// ===== tb/timer16_capture_compare_ctrl_tb_top.sv
// self-checking bench for the timer control block
// assumes: pin model on the capture side, checker bound to the design
`timescale 1ns/1ps
module timer16_capture_compare_ctrl_tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpuHalt = 1'b0, irqMaskSet = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic pready, pslverr, comparePinA, comparePinAEnable, comparePinB, comparePinBEnable;
   logic timerIrq, captureInputA, captureInputB, extClkIn;
   logic [7:0] a, b, junk;
   logic [33:0] note, q[$];
   int n_errors = 0, checks = 0, cycles = 0, seed;
   int step[4] = '{20, 40, 10, 5};
   always #4 clk = ~clk;
   timer16_capture_compare_ctrl u_dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .captureInputA(captureInputA),
      .captureInputB(captureInputB), .extClkIn(extClkIn), .cpuHalt(cpuHalt),
      .irqMaskSet(irqMaskSet), .comparePinA(comparePinA), .comparePinAEnable(comparePinAEnable),
      .comparePinB(comparePinB), .comparePinBEnable(comparePinBEnable), .timerIrq(timerIrq));
   pin_partner u_pins (.clk(clk), .captureInputA(captureInputA),
      .captureInputB(captureInputB), .extClkIn(extClkIn));
   task automatic results;
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp_bus(input string nm, input logic [32:0] e, input logic [32:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_pin(input string nm, input logic e, input logic g);
      cmp_bus(nm, {32'h0, e}, {32'h0, g});
   endtask
   task automatic irqIs(input logic e);
      cmp_pin("timerIrq", e, timerIrq);
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
      input logic [33:0] nt, output logic [7:0] rd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      if (!wr) q.push_back(nt);
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      apb(1'b1, idx, v, 34'h0, junk);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00, {2'b10, 24'h00_0000, e}, junk);
   endtask
   task automatic peek(input logic [7:0] idx, output logic [7:0] v);
      apb(1'b0, idx, 8'h00, 34'h0, v);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // ------------
   // answer monitor
   // ------------
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         note = q.pop_front();
         if (note[33]) cmp_bus("prdata", note[32:0], {pslverr, prdata});
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end
   // ------------
   // main sequence
   // ------------
   initial begin
      seed = 32'h0000_b134;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(timer16_pkg::IDX_CTRL_A, 8'h00);
      rd(timer16_pkg::IDX_CTRL_B, 8'h00);
      rd(timer16_pkg::IDX_CMPA_HI, 8'h80);
      apb(1'b0, 8'h50, 8'h00, {2'b11, 32'h0000_0000}, junk);
      // counter wraps a few steps after reset
      settle(40);
      irqIs(1'b0);
      rd(timer16_pkg::IDX_STATUS, 8'h20);
      wr(timer16_pkg::IDX_CTRL_A, 8'h20);
      settle(3);
      irqIs(1'b1);
      @(posedge clk);
      irqMaskSet <= 1'b1;
      settle(3);
      irqIs(1'b0);
      @(posedge clk);
      irqMaskSet <= 1'b0;
      peek(timer16_pkg::IDX_CNT_LO, a);
      settle(3);
      irqIs(1'b0);
      rd(timer16_pkg::IDX_STATUS, 8'h00);
      wr(timer16_pkg::IDX_CTRL_A, 8'h82);
      u_pins.setPin(1'b0, 1'b1);
      settle(1);
      irqIs(1'b1);
      rd(timer16_pkg::IDX_STATUS, 8'h80);
      peek(timer16_pkg::IDX_CAPA_LO, a);
      u_pins.setPin(1'b0, 1'b0);
      settle(1);
      irqIs(1'b0);
      wr(timer16_pkg::IDX_CTRL_A, 8'h80);
      u_pins.setPin(1'b0, 1'b1);
      rd(timer16_pkg::IDX_STATUS, 8'h00);
      u_pins.setPin(1'b0, 1'b0);
      rd(timer16_pkg::IDX_STATUS, 8'h80);
      peek(timer16_pkg::IDX_CAPA_LO, a);
      @(posedge clk);
      cpuHalt <= 1'b1;
      peek(timer16_pkg::IDX_CNT_LO, a);
      u_pins.setPin(1'b1, 1'b0);
      settle(20);
      peek(timer16_pkg::IDX_CNT_LO, b);
      cmp_bus("heldCount", {25'h0, a}, {25'h0, b});
      irqIs(1'b0);
      @(posedge clk);
      cpuHalt <= 1'b0;
      settle(3);
      irqIs(1'b1);
      rd(timer16_pkg::IDX_STATUS, 8'h10);
      peek(timer16_pkg::IDX_CAPB_LO, a);
      wr(timer16_pkg::IDX_CTRL_B, 8'hC0);
      settle(2);
      cmp_pin("comparePinAEnable", 1'b1, comparePinAEnable);
      cmp_pin("comparePinBEnable", 1'b1, comparePinBEnable);
      for (int i = 0; i < 2; i++) begin
         wr(timer16_pkg::IDX_CTRL_A, (i == 1) ? 8'h1C : 8'h19);
         settle(2);
         cmp_pin("comparePinA", i == 0, comparePinA);
         cmp_pin("comparePinB", i == 1, comparePinB);
      end
      wr(timer16_pkg::IDX_CMPA_HI, 8'h00);
      wr(timer16_pkg::IDX_CMPA_LO, 8'h03);
      wr(timer16_pkg::IDX_CTRL_B, 8'hE0);
      wr(timer16_pkg::IDX_CTRL_A, 8'h19);
      settle(2);
      cmp_pin("comparePinA", 1'b0, comparePinA);
      cmp_pin("comparePinB", 1'b1, comparePinB);
      wr(timer16_pkg::IDX_CTRL_A, 8'h04);
      u_pins.setPin(1'b0, 1'b1);
      u_pins.setPin(1'b0, 1'b0);
      settle(4);
      cmp_pin("comparePinA", 1'b1, comparePinA);
      rd(timer16_pkg::IDX_CAPA_LO, 8'hFD);
      settle(40);
      cmp_pin("comparePinA", 1'b0, comparePinA);
      // top bit kept set so the running counter never meets these values
      repeat (3) begin
         r = $random(seed);
         wr(timer16_pkg::IDX_CMPB_HI, {1'b1, r[6:0]});
         wr(timer16_pkg::IDX_CMPB_LO, r[15:8]);
         rd(timer16_pkg::IDX_CMPB_HI, {1'b1, r[6:0]});
         rd(timer16_pkg::IDX_CMPB_LO, r[15:8]);
      end
      // divider reads 80 clocks apart, a multiple of every divider; external reads 44 apart
      for (int cs = 0; cs < 4; cs++) begin
         wr(timer16_pkg::IDX_CTRL_B, {4'h0, cs[1:0], 1'b0, cs == 3});
         peek(timer16_pkg::IDX_CNT_LO, a);
         if (cs == 3) u_pins.extBurst(5);
         else repeat (76) @(posedge clk);
         peek(timer16_pkg::IDX_CNT_LO, b);
         cmp_bus("countStep", {25'h0, 8'(a + step[cs])}, {25'h0, b});
      end
      results();
   end
endmodule
